// >>> include/adc_ctl_pkg.sv
// Constants, register map and conversion timing for the converter sequencer
package adc_ctl_pkg;

	// Register indices on the plain register port
	localparam logic [3:0] ADDR_MODE      = 4'h0; // converter_mode_control
	localparam logic [3:0] ADDR_CHAN      = 4'h1; // input_channel_select
	localparam logic [3:0] ADDR_CMP_MODE  = 4'h2; // low_voltage_compare_mode
	localparam logic [3:0] ADDR_THRESH    = 4'h3; // low_voltage_threshold
	localparam logic [3:0] ADDR_RESULT    = 4'h4; // result_word, 16 bits
	localparam logic [3:0] ADDR_RESULT_HI = 4'h5; // result_high_byte

	// Reset values
	localparam logic [7:0] MODE_RESET   = 8'h00;
	localparam logic [7:0] CHAN_RESET   = 8'h00;
	localparam logic [7:0] CMP_RESET    = 8'h00;
	localparam logic [7:0] THRESH_RESET = 8'h00;
	localparam logic [9:0] RESULT_RESET = 10'h000;

	// Mode register fields
	localparam int RUN_BIT   = 7; // conversion_run_bit
	localparam int SCAN_BIT  = 6; // scan_select_bit
	localparam int TIME_MSB  = 5; // conv_time_sel_hi
	localparam int TIME_LSB  = 3; // conv_time_sel_lo
	localparam int FAST_HI   = 2; // fast_mode_high_ref
	localparam int FAST_LO   = 1; // fast_mode_low_ref
	localparam int BOOST_BIT = 0; // boost_ref_enable

	// Channel register fields
	localparam int EDGE_MSB      = 7; // external trigger edge select
	localparam int EDGE_LSB      = 6;
	localparam int HW_TRIG_BIT   = 5; // hw_trigger_select
	localparam int TIMER_SRC_BIT = 4; // 1: timer_match_event, 0: pin
	localparam int CHAN_MSB      = 2;

	// Compare mode fields
	localparam int CMP_EN_BIT    = 7;
	localparam int CMP_BELOW_BIT = 6; // 0: high byte >= threshold, 1: below

	// Result layout
	localparam int RES_BITS = 10;
	localparam logic [5:0] RES_PAD = 6'h00;
	localparam logic [9:0] MSB_TRIAL = 10'h200;
	localparam logic [3:0] MSB_INDEX = 4'h9;

	// Decision step padding covers the comparator synchroniser delay
	localparam logic [5:0] STEP_EXTRA = 6'h03;

	// Conversion time in peripheral clocks from {fast hi, fast lo, time sel}
	function automatic logic [8:0] conv_cycles(input logic [4:0] sel);
		unique case (sel)
			5'h00: conv_cycles = 9'h120;
			5'h01: conv_cycles = 9'h0f0;
			5'h02: conv_cycles = 9'h0c0;
			5'h04: conv_cycles = 9'h090;
			5'h05: conv_cycles = 9'h078;
			5'h06: conv_cycles = 9'h060;
			5'h08: conv_cycles = 9'h060;
			5'h09: conv_cycles = 9'h048;
			5'h0a: conv_cycles = 9'h030;
			5'h0b: conv_cycles = 9'h018;
			5'h0c: conv_cycles = 9'h0e0;
			5'h0d: conv_cycles = 9'h0a8;
			5'h0e: conv_cycles = 9'h070;
			5'h0f: conv_cycles = 9'h038;
			5'h10: conv_cycles = 9'h048;
			5'h11: conv_cycles = 9'h036;
			5'h12: conv_cycles = 9'h024;
			5'h13: conv_cycles = 9'h012;
			default: conv_cycles = 9'h120; // Prohibited codes run slowest
		endcase
	endfunction

endpackage

// >>> design/approx_engine.sv
// Bit-decision engine: sample phase then ten comparator steps, MSB first
`timescale 1ns/1ps
module approx_engine
	import adc_ctl_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_reset,
	input  wire logic       i_start,
	input  wire logic       i_abort,
	input  wire logic [6:0] i_sample_len,
	input  wire logic [5:0] i_step_len,
	input  wire logic       i_comparator,
	output logic            o_busy,
	output logic            o_sample,
	output logic [9:0]      o_trial,
	output logic            o_done,
	output logic [9:0]      o_result
);
	typedef enum logic [1:0] {IDLE, SAMPLE, DECIDE} phase_e;

	phase_e     phase_q, phase_d;
	logic [6:0] cnt_q, cnt_d;
	logic [3:0] idx_q, idx_d;
	logic [9:0] trial_q, trial_d;
	logic [9:0] result_q, result_d;
	logic       done_q, done_d;
	logic       sample_q, sample_d;
	logic       comp_meta_q, comp_q;

	// Comparator is analog-side, so two flops before use
	always_ff @(posedge i_clock) begin
		comp_meta_q <= i_comparator;
		comp_q      <= comp_meta_q;
	end

	// Sequencing of sample and decisions
	always_comb begin
		phase_d  = phase_q;
		cnt_d    = cnt_q;
		idx_d    = idx_q;
		trial_d  = trial_q;
		result_d = result_q;
		done_d   = 1'b0;
		sample_d = 1'b0;
		if (i_abort) begin
			phase_d = IDLE;
		end else begin
			unique case (phase_q)
				IDLE: begin
					if (i_start) begin
						phase_d  = SAMPLE; // Input tracked once per conversion
						sample_d = 1'b1;
						cnt_d    = i_sample_len - 7'h01;
					end
				end
				SAMPLE: begin
					sample_d = 1'b1;
					if (cnt_q == 7'h00) begin
						phase_d  = DECIDE; // Held value frozen from here
						sample_d = 1'b0;
						idx_d    = MSB_INDEX;
						trial_d  = MSB_TRIAL; // Start at the top bit
						cnt_d    = {1'b0, i_step_len} - 7'h01;
					end else begin
						cnt_d = cnt_q - 7'h01;
					end
				end
				DECIDE: begin
					if (cnt_q == 7'h00) begin
						// Drop the trial bit when input is below the tap
						if (!comp_q) begin
							trial_d[idx_q] = 1'b0;
						end
						if (idx_q == 4'h0) begin
							phase_d  = IDLE;
							done_d   = 1'b1;
							result_d = trial_d;
						end else begin
							idx_d = idx_q - 4'h1;
							trial_d[idx_d] = 1'b1;
							cnt_d = {1'b0, i_step_len} - 7'h01;
						end
					end else begin
						cnt_d = cnt_q - 7'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			phase_q  <= IDLE;
			cnt_q    <= 7'h00;
			idx_q    <= 4'h0;
			trial_q  <= 10'h000;
			result_q <= RESULT_RESET;
			done_q   <= 1'b0;
			sample_q <= 1'b0;
		end else begin
			phase_q  <= phase_d;
			cnt_q    <= cnt_d;
			idx_q    <= idx_d;
			trial_q  <= trial_d;
			result_q <= result_d;
			done_q   <= done_d;
			sample_q <= sample_d;
		end
	end

	assign o_busy   = (phase_q != IDLE);
	assign o_sample = sample_q;
	assign o_trial  = trial_q;
	assign o_done   = done_q;
	assign o_result = result_q;

	AST_MSB_FIRST: assert property (@(posedge i_clock) disable iff (i_reset)
		(phase_q == SAMPLE && cnt_q == 7'h00 && !i_abort) |=> trial_q == 10'h200)
		else $error("first trial code is not the top bit");
	AST_HOLD_DURING_DECIDE: assert property (@(posedge i_clock) disable iff (i_reset)
		(phase_q == DECIDE) |-> !sample_q)
		else $error("sampling while deciding bits");
	AST_DONE_PULSE: assert property (@(posedge i_clock) disable iff (i_reset)
		done_q |=> !done_q)
		else $error("done longer than one cycle");
endmodule // approx_engine

// >>> design/adc_sequencer_control.sv
// Converter sequencer: registers, triggers, channel scan, result and interrupt
// Operation
// - Convert selected input of eight, 10-bit results
// - Pulse done interrupt after every conversion while compare is disabled
// - Compare gating: interrupt only when threshold condition holds
// - Resolve bits MSB first using comparator
// - Approximation register never directly readable or writable
// - Result word: ten high bits, six zeros
// - High byte view returns top eight bits
// - Unused analog pins stay digital inputs
// - Mode register resets zero, byte/bit access
// - Run bit starts and stops conversion
// - Scan bit picks single channel or scan
// - Time and fast bits set conversion length
// - Threshold compare at each conversion end
// - Start by software, timer match, pin edge
// - Sample once, hold through bit decisions
// - Boost reference follows run with enable clear
`timescale 1ns/1ps
module adc_sequencer_control
	import adc_ctl_pkg::*;
(
	input  wire logic        I_CLOCK,
	input  wire logic        I_RESET,
	input  wire logic [3:0]  I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WRITE,
	input  wire logic        I_READ,
	input  wire logic        I_BIT_ACCESS,
	input  wire logic [2:0]  I_BIT_INDEX,
	output logic      [15:0] O_RDATA,
	input  wire logic        I_COMPARATOR,
	input  wire logic        I_EXTERNAL_TRIGGER_PIN,
	input  wire logic        I_TIMER_MATCH_EVENT,
	output logic      [2:0]  O_CHANNEL,
	output logic             O_SAMPLE,
	output logic      [9:0]  O_TRIAL_CODE,
	output logic             O_BOOST_REF_ON,
	output logic             O_CONVERSION_DONE_IRQ,
	output logic      [7:0]  O_DIGITAL_INPUT_ENABLE
);
	import adc_ctl_pkg::*;

	logic [7:0]  mode_q, mode_d;
	logic [7:0]  chan_q, chan_d;
	logic [7:0]  cmpm_q, cmpm_d;
	logic [7:0]  thresh_q, thresh_d;
	logic [9:0]  result_q, result_d;
	logic [15:0] rdata_q, rdata_d;
	logic        irq_q, irq_d;
	logic        boost_q, boost_d;
	logic [7:0]  dig_en_q, dig_en_d;
	logic [2:0]  scan_ch_q, scan_ch_d;
	logic [2:0]  ch_q, ch_d;
	logic        start_q, start_d;
	logic        pend_q, pend_d;
	logic        run_prev_q;
	logic        ext_meta_q, ext_sync_q, ext_prev_q;

	logic        run, scan, hw_mode, trig_event, ext_edge;
	logic        eng_busy, eng_done;
	logic [9:0]  eng_result;
	logic [8:0]  conv_len;
	logic [6:0]  sample_len;
	logic [5:0]  step_len;
	logic [7:0]  wr_mask;
	logic [7:0]  wr_value;
	logic [7:0]  rd_byte;
	logic [7:0]  result_hi;

	assign run       = mode_q[RUN_BIT];
	assign scan      = mode_q[SCAN_BIT];
	assign hw_mode   = chan_q[HW_TRIG_BIT];
	assign result_hi = result_q[9:2];

	// Conversion length from the mode fields; sample gets a quarter, each decision step a sixteenth plus STEP_EXTRA
	assign conv_len   = conv_cycles({mode_q[FAST_HI], mode_q[FAST_LO],
		mode_q[TIME_MSB:TIME_LSB]});
	assign sample_len = conv_len[8:2];
	assign step_len   = conv_len[8:4] + STEP_EXTRA - 6'h00;

	// External pin is asynchronous: two flops, then edge detect on the second
	always_ff @(posedge I_CLOCK) begin
		ext_meta_q <= I_EXTERNAL_TRIGGER_PIN;
		ext_sync_q <= ext_meta_q;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			ext_prev_q <= 1'b0;
			run_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_sync_q;
			run_prev_q <= run;
		end
	end

	// Edge select: 00 none, 01 falling, 10 rising, 11 both
	assign ext_edge = (chan_q[EDGE_MSB] & ext_sync_q & ~ext_prev_q)
		| (chan_q[EDGE_LSB] & ~ext_sync_q & ext_prev_q);
	assign trig_event = chan_q[TIMER_SRC_BIT] ? I_TIMER_MATCH_EVENT : ext_edge;

	// Byte write or single-bit write into an 8-bit register
	always_comb begin
		wr_mask  = 8'hff;
		wr_value = I_WDATA;
		if (I_BIT_ACCESS) begin
			wr_mask  = 8'h01 << I_BIT_INDEX;
			wr_value = {8{I_WDATA[0]}};
		end
	end

	// Register writes; the approximation value has no address at all
	always_comb begin
		mode_d   = mode_q;
		chan_d   = chan_q;
		cmpm_d   = cmpm_q;
		thresh_d = thresh_q;
		if (I_WRITE) begin
			unique case (I_ADDR)
				ADDR_MODE:     mode_d   = (mode_q & ~wr_mask) | (wr_value & wr_mask);
				ADDR_CHAN:     chan_d   = (chan_q & ~wr_mask) | (wr_value & wr_mask);
				ADDR_CMP_MODE: cmpm_d   = (cmpm_q & ~wr_mask) | (wr_value & wr_mask);
				ADDR_THRESH:   thresh_d = (thresh_q & ~wr_mask) | (wr_value & wr_mask);
				default: ; // Result and unmapped addresses ignore writes
			endcase
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			mode_q   <= MODE_RESET;
			chan_q   <= CHAN_RESET;
			cmpm_q   <= CMP_RESET;
			thresh_q <= THRESH_RESET;
		end else begin
			mode_q   <= mode_d;
			chan_q   <= chan_d;
			cmpm_q   <= cmpm_d;
			thresh_q <= thresh_d;
		end
	end

	// Read path: data stand in the cycle after the strobe only
	always_comb begin
		rd_byte = 8'h00;
		rdata_d = 16'h0000;
		unique case (I_ADDR)
			ADDR_MODE:      rd_byte = mode_q;
			ADDR_CHAN:      rd_byte = chan_q;
			ADDR_CMP_MODE:  rd_byte = cmpm_q;
			ADDR_THRESH:    rd_byte = thresh_q;
			ADDR_RESULT_HI: rd_byte = result_hi;
			default:        rd_byte = 8'h00;
		endcase
		if (I_READ) begin
			if (I_ADDR == ADDR_RESULT) begin
				rdata_d = {result_q, RES_PAD};
			end else if (I_BIT_ACCESS) begin
				rdata_d = {15'h0000, rd_byte[I_BIT_INDEX]};
			end else begin
				rdata_d = {8'h00, rd_byte};
			end
		end
	end

	// Start control, trigger pending flag, channel stepping and results
	always_comb begin
		start_d   = 1'b0;
		pend_d    = pend_q;
		scan_ch_d = scan_ch_q;
		result_d  = result_q;
		irq_d     = 1'b0;
		// A trigger arriving with the start wins over the clear
		if (start_q) begin
			pend_d = 1'b0;
		end
		if (run && hw_mode && trig_event) begin
			pend_d = 1'b1;
		end
		if (!run) begin
			pend_d    = 1'b0;
			scan_ch_d = 3'h0;
		end else if (!eng_busy && !start_q && (!hw_mode || pend_q)) begin
			start_d = 1'b1; // Software mode repeats back to back
		end
		if (run && !run_prev_q) begin
			scan_ch_d = 3'h0;
		end
		if (eng_done && run) begin
			result_d = eng_result;
			// Threshold test on the fresh high byte
			if (!cmpm_q[CMP_EN_BIT]) begin
				irq_d = 1'b1;
			end else if (cmpm_q[CMP_BELOW_BIT]) begin
				irq_d = (eng_result[9:2] < thresh_q);
			end else begin
				irq_d = (eng_result[9:2] >= thresh_q);
			end
			if (scan) begin
				scan_ch_d = (scan_ch_q == chan_q[CHAN_MSB:0]) ? 3'h0 : scan_ch_q + 3'h1;
			end
		end
	end

	// Pins in use: the selected one, or every pin from 0 up to it in scan
	always_comb begin
		ch_d     = scan ? scan_ch_q : chan_q[CHAN_MSB:0];
		dig_en_d = 8'hff;
		for (int i = 0; i < 8; i++) begin
			if (scan ? (i <= int'(chan_q[CHAN_MSB:0])) : (i == int'(chan_q[CHAN_MSB:0]))) begin
				dig_en_d[i] = 1'b0;
			end
		end
		// Boost follows run when its own enable is clear
		boost_d = mode_q[BOOST_BIT] | run;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			start_q   <= 1'b0;
			pend_q    <= 1'b0;
			scan_ch_q <= 3'h0;
			result_q  <= RESULT_RESET;
			irq_q     <= 1'b0;
			rdata_q   <= 16'h0000;
			ch_q      <= 3'h0;
			dig_en_q  <= 8'hff;
			boost_q   <= 1'b0;
		end else begin
			start_q   <= start_d;
			pend_q    <= pend_d;
			scan_ch_q <= scan_ch_d;
			result_q  <= result_d;
			irq_q     <= irq_d;
			rdata_q   <= rdata_d;
			ch_q      <= ch_d;
			dig_en_q  <= dig_en_d;
			boost_q   <= boost_d;
		end
	end

	// Clearing run aborts any conversion in flight
	approx_engine u_engine (
		.i_clock      (I_CLOCK),
		.i_reset      (I_RESET),
		.i_start      (start_q),
		.i_abort      (!run),
		.i_sample_len (sample_len),
		.i_step_len   (step_len),
		.i_comparator (I_COMPARATOR),
		.o_busy       (eng_busy),
		.o_sample     (O_SAMPLE),
		.o_trial      (O_TRIAL_CODE),
		.o_done       (eng_done),
		.o_result     (eng_result)
	);

	assign O_RDATA                = rdata_q;
	assign O_CHANNEL              = ch_q;
	assign O_BOOST_REF_ON         = boost_q;
	assign O_CONVERSION_DONE_IRQ  = irq_q;
	assign O_DIGITAL_INPUT_ENABLE = dig_en_q;

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);

	AST_IRQ_UNGATED: assert property (eng_done && run && !cmpm_q[CMP_EN_BIT]
		|=> irq_q)
		else $error("done without interrupt");
	AST_IRQ_GATED: assert property (irq_q && cmpm_q[CMP_EN_BIT] |->
		(cmpm_q[CMP_BELOW_BIT] ? (result_hi < thresh_q) : (result_hi >= thresh_q)))
		else $error("interrupt although compare failed");
	AST_RESULT_ONLY_AT_END: assert property (!eng_done |=> $stable(result_q))
		else $error("result changed outside conversion end");
	AST_RESULT_LOW_ZERO: assert property (I_READ && I_ADDR == ADDR_RESULT
		|=> O_RDATA[5:0] == 6'h00 && O_RDATA[15:6] == $past(result_q))
		else $error("result word layout wrong");
	AST_HIGH_VIEW: assert property (I_READ && !I_BIT_ACCESS && I_ADDR == ADDR_RESULT_HI
		|=> O_RDATA == {8'h00, $past(result_hi)})
		else $error("high byte view wrong");
	AST_MODE_RESET: assert property (@(posedge I_CLOCK) $past(I_RESET) |-> mode_q == 8'h00)
		else $error("mode register not zero after reset");
	AST_STOPPED_QUIET: assert property (!run |=> !start_q ##1 !irq_q)
		else $error("activity while stopped");
	AST_BOOST_FOLLOWS: assert property (run |=> O_BOOST_REF_ON)
		else $error("boost reference off while running");

	COV_GATED_IRQ: cover property (irq_q && cmpm_q[CMP_EN_BIT]);
	COV_SCAN_WRAP: cover property (eng_done && scan && scan_ch_q == chan_q[CHAN_MSB:0]
		&& scan_ch_q != 3'h0);
	COV_HW_START: cover property (hw_mode && pend_q ##1 start_q);
endmodule // adc_sequencer_control

// >>> test/analog_front_model.sv
// Behavioural analog front end: input mux, sample-hold and comparator
`timescale 1ns/1ps
module analog_front_model (
	input  wire logic            i_clock,
	input  wire logic [7:0][9:0] i_levels,
	input  wire logic [2:0]      i_channel,
	input  wire logic            i_sample,
	input  wire logic [9:0]      i_trial,
	output logic                 o_comparator
);
	logic [9:0] held_q = 10'h000;

	// Track the pin while sampling, frozen once the switch opens
	always_ff @(posedge i_clock) begin
		if (i_sample) begin
			held_q <= i_levels[i_channel];
		end
	end

	// Held input at or above the trial tap; settles long before a step ends
	assign o_comparator = (held_q >= i_trial);
endmodule // analog_front_model

// >>> test/adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer with its analog model
`timescale 1ns/1ps
module adc_sequencer_control_tb;
	import adc_ctl_pkg::*;
	localparam logic [4:0] CODES [18] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h08,
		5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13};
	localparam int CYC [18] = '{288, 240, 192, 144, 120, 96, 96, 72, 48, 24, 224, 168, 112,
		56, 72, 54, 36, 18};
	logic            I_CLOCK, I_RESET, I_WRITE, I_READ, I_BIT_ACCESS, comparator;
	logic            I_EXTERNAL_TRIGGER_PIN, I_TIMER_MATCH_EVENT;
	logic            O_SAMPLE, O_BOOST_REF_ON, O_CONVERSION_DONE_IRQ, rd_seen;
	logic [3:0]      I_ADDR;
	logic [7:0]      I_WDATA, O_DIGITAL_INPUT_ENABLE, seen_mask;
	logic [2:0]      I_BIT_INDEX, O_CHANNEL;
	logic [15:0]     O_RDATA;
	logic [9:0]      O_TRIAL_CODE;
	logic [7:0][9:0] levels;
	logic [31:0]     seed;
	logic [15:0]     exp_q [$];
	int              n_fail, n_checks;

	adc_sequencer_control DUT (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WRITE(I_WRITE), .I_READ(I_READ), .I_BIT_ACCESS(I_BIT_ACCESS),
		.I_BIT_INDEX(I_BIT_INDEX), .O_RDATA(O_RDATA), .I_COMPARATOR(comparator),
		.I_EXTERNAL_TRIGGER_PIN(I_EXTERNAL_TRIGGER_PIN),
		.I_TIMER_MATCH_EVENT(I_TIMER_MATCH_EVENT), .O_CHANNEL(O_CHANNEL),
		.O_SAMPLE(O_SAMPLE), .O_TRIAL_CODE(O_TRIAL_CODE), .O_BOOST_REF_ON(O_BOOST_REF_ON),
		.O_CONVERSION_DONE_IRQ(O_CONVERSION_DONE_IRQ),
		.O_DIGITAL_INPUT_ENABLE(O_DIGITAL_INPUT_ENABLE));
	analog_front_model front (.i_clock(I_CLOCK), .i_levels(levels), .i_channel(O_CHANNEL),
		.i_sample(O_SAMPLE), .i_trial(O_TRIAL_CODE), .o_comparator(comparator));

	// 40 MHz clock
	initial begin
		I_CLOCK = 1'b0;
		forever #12.5 I_CLOCK = ~I_CLOCK;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	function automatic logic [7:0] mode_of(input logic [4:0] s, input logic scan);
		return {1'b1, scan, s[2:0], s[4], s[3], 1'b0};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] e);
		n_checks++;
		if (seen !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One bus cycle; a read leaves its expectation for the watcher
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic ba, input logic [2:0] bi, input logic [15:0] e);
		@(posedge I_CLOCK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_BIT_ACCESS <= ba;
		I_BIT_INDEX <= bi;
		I_WRITE <= w;
		I_READ <= !w;
		if (!w) exp_q.push_back(e);
		@(posedge I_CLOCK);
		I_WRITE <= 1'b0;
		I_READ <= 1'b0;
		I_BIT_ACCESS <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 1'b0, 3'h0, 16'h0000);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		acc(1'b0, a, 8'h00, 1'b0, 3'h0, e);
	endtask

	// Bounded watch for the done pulse; a missing one ends the run
	task automatic wait_irq(input int limit, input logic want);
		logic got;
		got = 1'b0;
		for (int i = 0; i < limit && !got; i++) begin
			@(posedge I_CLOCK);
			#1;
			got = (O_CONVERSION_DONE_IRQ === 1'b1);
		end
		check("done irq", {15'h0, got}, {15'h0, want});
		if (want && !got) tally_and_finish();
	endtask

	task automatic wait_sample(input logic want, input int limit, output int n);
		n = 0;
		while (O_SAMPLE !== want) begin
			@(posedge I_CLOCK);
			#1;
			n++;
			if (n > limit) begin
				check("sample wait", {15'h0, O_SAMPLE}, {15'h0, want});
				tally_and_finish();
			end
		end
	endtask

	// Select-mode conversion; the pin moves after sampling and must not show
	task automatic conv_one(input logic [2:0] ch);
		logic [9:0] v;
		int n;
		v = levels[ch];
		wr(ADDR_CHAN, {5'h00, ch});
		wr(ADDR_MODE, mode_of(5'h13, 1'b0));
		wait_sample(1'b1, 20, n);
		check("boost", {15'h0, O_BOOST_REF_ON}, 16'h0001);
		check("pins", {8'h00, O_DIGITAL_INPUT_ENABLE}, {8'h00, ~(8'h01 << ch)});
		// Reference starts cold here, so the first result is thrown away
		wait_irq(100, 1'b1);
		wait_sample(1'b1, 20, n);
		wait_sample(1'b0, 20, n);
		check("first trial", {6'h00, O_TRIAL_CODE}, 16'h0200);
		levels[ch] = ~v;
		wait_irq(100, 1'b1);
		wr(ADDR_MODE, 8'h00);
		rd(ADDR_RESULT, {v, RES_PAD});
		rd(ADDR_RESULT_HI, {8'h00, v[9:2]});
		levels[ch] = v;
	endtask

	// Read data stand one cycle after the strobe; compare them there
	always @(posedge I_CLOCK) rd_seen <= I_READ;
	always @(negedge I_CLOCK) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0) begin
			check("read data", O_RDATA, exp_q.pop_front());
		end
		if (O_SAMPLE === 1'b1) begin
			seen_mask[O_CHANNEL] = 1'b1;
		end
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge I_CLOCK);
		check("run length", 16'h0001, 16'h0000);
		tally_and_finish();
	end

	initial begin
		int n;
		{I_WRITE, I_READ, I_BIT_ACCESS, I_EXTERNAL_TRIGGER_PIN, I_TIMER_MATCH_EVENT} = '0;
		{I_ADDR, I_WDATA, I_BIT_INDEX, seen_mask, rd_seen} = '0;
		n_fail = 0;
		n_checks = 0;
		seed = 32'h89c36ba4;
		for (int c = 0; c < 8; c++) begin
			seed = xs(seed);
			levels[c] = seed[9:0];
		end
		levels[5] = 10'h3ff;
		levels[2] = 10'h000;
		I_RESET = 1'b1;
		repeat (8) @(posedge I_CLOCK);
		I_RESET <= 1'b0;
		// Reset values, unmapped read, single-bit access
		rd(ADDR_MODE, 16'h0000);
		rd(ADDR_CHAN, 16'h0000);
		rd(ADDR_CMP_MODE, 16'h0000);
		rd(ADDR_THRESH, 16'h0000);
		rd(4'hf, 16'h0000);
		acc(1'b1, ADDR_MODE, 8'h01, 1'b1, 3'h6, 16'h0000);
		rd(ADDR_MODE, 16'h0040);
		acc(1'b0, ADDR_MODE, 8'h00, 1'b1, 3'h6, 16'h0001);
		wr(ADDR_MODE, 8'h00);
		$display("test registers done");
		conv_one(3'h1);
		conv_one(3'h5);
		conv_one(3'h2);
		$display("test select conversions done");
		// Stopped: no pulses, result kept, reference off
		wait_irq(150, 1'b0);
		check("idle sample", {15'h0, O_SAMPLE}, 16'h0000);
		check("boost off", {15'h0, O_BOOST_REF_ON}, 16'h0000);
		rd(ADDR_RESULT, {levels[2], RES_PAD});
		$display("test stopped done");
		// Threshold gating, both comparison senses, on and off the boundary
		levels[0] = 10'h100;
		wr(ADDR_CHAN, 8'h00);
		// Reference warmed well past its settling time, so first results count
		wr(ADDR_MODE, 8'h01);
		repeat (48) @(posedge I_CLOCK);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CMP_MODE, {1'b1, ~i[1], 6'h00});
			wr(ADDR_THRESH, 8'h40 + 8'(i[0]));
			wr(ADDR_MODE, mode_of(5'h13, 1'b0) | 8'h01);
			wait_irq(150, i[0] ^ i[1]);
			wr(ADDR_MODE, 8'h01);
		end
		check("boost held", {15'h0, O_BOOST_REF_ON}, 16'h0001);
		wr(ADDR_CMP_MODE, 8'h00);
		$display("test compare done");
		// Timer match then pin edge; the timer trigger is checked for exactly one result
		wr(ADDR_CHAN, 8'h34);
		wr(ADDR_MODE, mode_of(5'h13, 1'b0));
		wait_irq(100, 1'b0);
		I_TIMER_MATCH_EVENT <= 1'b1;
		@(posedge I_CLOCK);
		I_TIMER_MATCH_EVENT <= 1'b0;
		wait_irq(100, 1'b1);
		wait_irq(100, 1'b0);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CHAN, 8'ha4);
		wr(ADDR_MODE, mode_of(5'h13, 1'b0));
		wait_irq(100, 1'b0);
		I_EXTERNAL_TRIGGER_PIN <= 1'b1;
		wait_irq(100, 1'b1);
		wr(ADDR_MODE, 8'h00);
		// Falling-edge sense on the same pin
		wr(ADDR_CHAN, 8'h64);
		wr(ADDR_MODE, mode_of(5'h13, 1'b0));
		wait_irq(100, 1'b0);
		I_EXTERNAL_TRIGGER_PIN <= 1'b0;
		wait_irq(100, 1'b1);
		wr(ADDR_MODE, 8'h00);
		$display("test triggers done");
		// Scan over channels zero to two
		wr(ADDR_CHAN, 8'h02);
		seen_mask = 8'h00;
		wr(ADDR_MODE, mode_of(5'h13, 1'b1));
		repeat (4) wait_irq(100, 1'b1);
		check("scan pins", {8'h00, O_DIGITAL_INPUT_ENABLE}, 16'h00f8);
		wr(ADDR_MODE, 8'h00);
		check("scan channels", {8'h00, seen_mask}, 16'h0007);
		$display("test scan done");
		// Sample phase length for every permitted time code
		for (int k = 0; k < 18; k++) begin
			wr(ADDR_MODE, mode_of(CODES[k], 1'b0));
			wait_sample(1'b1, 20, n);
			wait_sample(1'b0, 100, n);
			check("sample length", 16'(n), 16'(CYC[k] >> 2));
			wr(ADDR_MODE, 8'h00);
		end
		$display("test time codes done");
		// Reset in mid-conversion stops sampling and brings mode and result back to their reset values
		wr(ADDR_MODE, mode_of(5'h13, 1'b1));
		wait_sample(1'b1, 20, n);
		I_RESET <= 1'b1;
		repeat (2) @(posedge I_CLOCK);
		I_RESET <= 1'b0;
		check("reset sample", {15'h0, O_SAMPLE}, 16'h0000);
		rd(ADDR_MODE, 16'h0000);
		rd(ADDR_RESULT, {RESULT_RESET, RES_PAD});
		repeat (2) @(posedge I_CLOCK);
		$display("test reset done");
		tally_and_finish();
	end
endmodule // adc_sequencer_control_tb
